// file: crss_board.sv
// board reset circuit model: drives the reset pin and the two straps
// assumes the bench commands the reset hold and the strap levels
`timescale 1ns/100ps
`default_nettype none
module crss_board (
  input  wire logic ref_clk_i,
  input  wire logic hold_i,
  input  wire logic pol_i,
  input  wire logic csel_i,
  output logic      chip_reset_in_n_o,
  output logic      pol_strap_o,
  output logic      clk_strap_o
);
  logic       flip_q = 1'b0;
  logic [3:0] keep_q = 4'h0;
  always_ff @(posedge ref_clk_i) flip_q <= ~flip_q;
  always_ff @(posedge ref_clk_i) keep_q <= hold_i ? 4'hF : keep_q - 4'(keep_q != 4'h0);
  assign chip_reset_in_n_o = ~hold_i;
  // after the hold time the straps float; a toggling level exposes a missing latch
  assign pol_strap_o = (hold_i || keep_q != 4'h0) ? pol_i : flip_q;
  assign clk_strap_o = (hold_i || keep_q != 4'h0) ? csel_i : ~flip_q;
endmodule
`default_nettype wire

// file: crss_map.svh
// timing counts and reset values for the chip reset and strap sequencer
// assumes a 50 MHz system clock and a 25 MHz reference derived by enable
`ifndef CRSS_MAP_SVH
`define CRSS_MAP_SVH

`define CRSS_SYS_CLK_HZ        50000000
`define CRSS_REF_CLK_HZ        25000000
`define CRSS_PLL_OUT_HZ        125000000
`define CRSS_REF_DIV           (`CRSS_SYS_CLK_HZ / `CRSS_REF_CLK_HZ)
`define CRSS_PLL_MULT          (`CRSS_PLL_OUT_HZ / `CRSS_REF_CLK_HZ)
`define CRSS_STRETCH_MS        200
`define CRSS_STRETCH_TICKS     (`CRSS_STRETCH_MS * (`CRSS_REF_CLK_HZ / 1000))
`define CRSS_MIN_RESET_CYCLES  256
`define CRSS_CNT_W             23
`define CRSS_SYNC_DEPTH        3
`define CRSS_NUM_PINS          3
`define CRSS_PIN_RESET         0
`define CRSS_PIN_POLARITY      1
`define CRSS_PIN_CLKSRC        2
`define CRSS_PIN_RESET_VAL     3'h7

`endif

// file: crss_pkg.sv
// types of the chip reset and strap sequencer
// the timing figures live in crss_map.svh
`include "crss_map.svh"

package crss_pkg;

  typedef enum logic [1:0] {
    CRSS_CHIP_RESET = 2'b00,
    CRSS_STRETCH    = 2'b01,
    CRSS_RUN        = 2'b10
  } crss_state_t;

  typedef struct packed {
    crss_state_t                    state;
    logic [`CRSS_NUM_PINS-1:0]      sync1;
    logic [`CRSS_NUM_PINS-1:0]      sync2;
    logic [`CRSS_NUM_PINS-1:0]      sync3;
    logic [`CRSS_NUM_PINS-1:0]      pin_val;
    logic                           pol_strap;
    logic                           clk_strap;
    logic [`CRSS_CNT_W-1:0]         stretch_cnt;
    logic [$clog2(`CRSS_REF_DIV)-1:0] ref_div;
    logic                           ref_tick;
    logic                           rst_out_lvl;
    logic                           core_rst_n;
  } crss_regs_t;

endpackage

// file: crss_seq_props.sv
// port assertions for the chip reset and strap sequencer
// assumes a bind onto crss_sequencer with its stretch parameter
`timescale 1ns/100ps
`default_nettype none
module crss_seq_props #(
  parameter int unsigned STRETCH_TICKS = 8
) (
  input wire logic       ref_clk_i,
  input wire logic       rst_n_i,
  input wire logic       chip_reset_in_n_i,
  input wire logic       watchdog_expire_i,
  input wire logic       static_oe_req_i,
  input wire logic       serial_rts_req_i,
  input wire logic       system_reset_out_o,
  input wire logic       static_output_enable_n_o,
  input wire logic       static_output_enable_n_oe_o,
  input wire logic       serial_request_to_send_n_o,
  input wire logic       serial_request_to_send_n_oe_o,
  input wire logic       chip_outputs_en_o,
  input wire logic       core_reset_n_o,
  input wire logic       pll_ref_tick_o,
  input wire logic [7:0] pll_mult_o,
  input wire logic       cpu_clk_from_pll_o,
  input wire logic       mac_tx_clk_tick_o
);
  logic [15:0] low_q;
  // one cycle of slack: the release edge itself may be counted either way
  always_ff @(posedge ref_clk_i) low_q <= (!rst_n_i || core_reset_n_o) ? 16'h0 : low_q + 16'h1;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_pads_tristate: assert property (!chip_reset_in_n_i [*6] |-> !static_output_enable_n_oe_o &&
    !serial_request_to_send_n_oe_o && !chip_outputs_en_o) else $error("pads driven in reset");
  a_stretch_long: assert property ($rose(core_reset_n_o) |-> low_q >= 16'(2 * STRETCH_TICKS - 1))
    else $error("reset stretch too short");
  a_wd_reset_out: assert property (watchdog_expire_i && core_reset_n_o |=>
    system_reset_out_o != $past(system_reset_out_o)) else $error("watchdog missed reset out");
  a_wd_core_rst: assert property (watchdog_expire_i |=> !core_reset_n_o) else $error("core not reset");
  a_rts_follow: assert property (serial_request_to_send_n_o == !serial_rts_req_i)
    else $error("rts level wrong");
  a_soe_follow: assert property (static_output_enable_n_o == !static_oe_req_i)
    else $error("static oe level wrong");
  a_run_drives: assert property (core_reset_n_o |-> static_output_enable_n_oe_o &&
    serial_request_to_send_n_oe_o) else $error("pads not driven in run");
  a_pll_ratio: assert property (pll_mult_o == 8'h05) else $error("pll ratio wrong");
  a_tick_rate: assert property (pll_ref_tick_o |=> !pll_ref_tick_o ##1 pll_ref_tick_o)
    else $error("ref tick rate wrong");
  a_mac_tick: assert property (mac_tx_clk_tick_o == pll_ref_tick_o) else $error("mac tick");
  a_strap_held: assert property (core_reset_n_o && $past(core_reset_n_o) |->
    $stable(cpu_clk_from_pll_o)) else $error("clock strap changed");
endmodule
bind crss_sequencer crss_seq_props #(.STRETCH_TICKS(STRETCH_TICKS)) i_crss_seq_props (.*);
`default_nettype wire

// file: crss_sequencer.sv
// chip reset sequencer: reset pin filter, strap capture, stretched reset out
// assumes one 50 MHz clock; pins arrive unsynchronised, watchdog is on-clock
// Function
// - a chip reset input held low for 256 or more reference cycles is a full chip reset; here any low that passes the pin filter starts one, however short.
// - while in chip reset every output pin except the system reset output is released to high impedance.
// - a chip reset asserts the system reset output for at least 200 ms.
// - a watchdog expiry asserts the system reset output for at least 200 ms too.
// - the polarity strap sampled 0 makes the reset output active high, 1 active low.
// - the clock source strap sampled 0 selects the PLL as CPU clock, 1 is factory test.
// - after reset the clock source strap pin becomes the active-low request-to-send output.
// - after reset the polarity strap pin becomes the active-low static output enable.
// - the 25 MHz reference feeds the PLL that makes the 125 MHz system clock.
// - the ethernet transmit clocking runs straight from the 25 MHz reference.
// - a watchdog expiry also resets the device's own logic.
`timescale 1ns/100ps
`default_nettype none

`include "crss_map.svh"

module crss_sequencer #(
  parameter int unsigned STRETCH_TICKS = `CRSS_STRETCH_TICKS
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        chip_reset_in_n_i,
  input  wire logic        watchdog_expire_i,
  input  wire logic        reset_out_polarity_strap_i,
  input  wire logic        cpu_clock_source_strap_i,
  input  wire logic        static_oe_req_i,
  input  wire logic        serial_rts_req_i,
  output logic             system_reset_out_o,
  output logic             system_reset_out_oe_o,
  output logic             static_output_enable_n_o,
  output logic             static_output_enable_n_oe_o,
  output logic             serial_request_to_send_n_o,
  output logic             serial_request_to_send_n_oe_o,
  output logic             chip_outputs_en_o,
  output logic             core_reset_n_o,
  output logic             pll_ref_tick_o,
  output logic [7:0]       pll_mult_o,
  output logic             cpu_clk_from_pll_o,
  output logic             mac_tx_clk_tick_o
);

  // the count runs from the full tick figure down to zero, so the stretch is
  // never shorter than the minimum; it may overrun by up to one clock
  localparam logic [`CRSS_CNT_W-1:0] STRETCH_LOAD = `CRSS_CNT_W'(STRETCH_TICKS);
  localparam int unsigned DIV_W = $clog2(`CRSS_REF_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(`CRSS_REF_DIV - 1);

  crss_pkg::crss_regs_t r_q;
  crss_pkg::crss_regs_t r_d;

  logic reset_held;
  logic reset_released;

  // pin level seen by the core once two late stages agree
  assign reset_held     = ~r_q.pin_val[`CRSS_PIN_RESET];
  assign reset_released = (r_q.state == crss_pkg::CRSS_CHIP_RESET) && !reset_held;

  always_comb begin
    r_d = r_q;

    // three-stage synchronisers; a change counts once stages two and three agree
    r_d.sync1[`CRSS_PIN_RESET]    = chip_reset_in_n_i;
    r_d.sync1[`CRSS_PIN_POLARITY] = reset_out_polarity_strap_i;
    r_d.sync1[`CRSS_PIN_CLKSRC]   = cpu_clock_source_strap_i;
    r_d.sync2 = r_q.sync1;
    r_d.sync3 = r_q.sync2;
    for (int i = 0; i < `CRSS_NUM_PINS; i++) begin
      if (r_q.sync2[i] == r_q.sync3[i]) begin
        r_d.pin_val[i] = r_q.sync3[i];
      end
    end

    // reference enable at half the system rate feeds the pll and the stretch counter
    r_d.ref_tick = 1'b0;
    if (r_q.ref_div == DIV_LAST) begin
      r_d.ref_div  = '0;
      r_d.ref_tick = 1'b1;
    end else begin
      r_d.ref_div = r_q.ref_div + DIV_W'(1);
    end

    unique case (r_q.state)
      crss_pkg::CRSS_CHIP_RESET: begin
        // a low shorter than the documented minimum is still honoured: the
        // board owns the hold time, and ignoring a glitch would be riskier
        r_d.core_rst_n  = 1'b0;
        r_d.stretch_cnt = STRETCH_LOAD;
        // straps follow the pins until the release edge freezes them
        r_d.pol_strap   = r_q.pin_val[`CRSS_PIN_POLARITY];
        r_d.clk_strap   = r_q.pin_val[`CRSS_PIN_CLKSRC];
        if (reset_released) begin
          r_d.state = crss_pkg::CRSS_STRETCH;
        end
      end
      crss_pkg::CRSS_STRETCH: begin
        r_d.core_rst_n = 1'b0;
        if (reset_held) begin
          r_d.state = crss_pkg::CRSS_CHIP_RESET;
        end else if (watchdog_expire_i) begin
          r_d.stretch_cnt = STRETCH_LOAD;
        end else if (r_q.stretch_cnt == '0) begin
          r_d.state      = crss_pkg::CRSS_RUN;
          r_d.core_rst_n = 1'b1;
        end else if (r_q.ref_tick) begin
          r_d.stretch_cnt = r_q.stretch_cnt - `CRSS_CNT_W'(1);
        end
      end
      crss_pkg::CRSS_RUN: begin
        r_d.core_rst_n = 1'b1;
        if (reset_held) begin
          r_d.state      = crss_pkg::CRSS_CHIP_RESET;
          r_d.core_rst_n = 1'b0;
        end else if (watchdog_expire_i) begin
          r_d.state       = crss_pkg::CRSS_STRETCH;
          r_d.stretch_cnt = STRETCH_LOAD;
          r_d.core_rst_n  = 1'b0;
        end
      end
      default: begin
        r_d.state = crss_pkg::CRSS_CHIP_RESET;
      end
    endcase

    // reset output level: asserted in every state but run; strap 0 means active high
    r_d.rst_out_lvl = (r_d.state != crss_pkg::CRSS_RUN) ^ r_d.pol_strap;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      r_q             <= '0;
      r_q.state       <= crss_pkg::CRSS_CHIP_RESET;
      r_q.sync1       <= `CRSS_PIN_RESET_VAL;
      r_q.sync2       <= `CRSS_PIN_RESET_VAL;
      r_q.sync3       <= `CRSS_PIN_RESET_VAL;
      r_q.pin_val     <= `CRSS_PIN_RESET_VAL;
      r_q.pol_strap   <= 1'b1;
      r_q.stretch_cnt <= STRETCH_LOAD;
      r_q.rst_out_lvl <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  // state decode for the pad enables
  logic in_chip_reset;
  assign in_chip_reset = (r_q.state == crss_pkg::CRSS_CHIP_RESET);

  // reset out level is a flop, so it cannot glitch while the straps settle
  assign system_reset_out_o            = r_q.rst_out_lvl;

  // the reset output must keep driving while the chip is reset, so it alone
  // stays enabled; every other pad is released
  assign system_reset_out_oe_o         = 1'b1;

  // pads released in chip reset, driven again once the stretch begins
  assign chip_outputs_en_o             = !in_chip_reset;
  assign static_output_enable_n_oe_o   = !in_chip_reset;
  assign serial_request_to_send_n_oe_o = !in_chip_reset;

  // shared strap pins take their normal active-low roles after reset
  assign static_output_enable_n_o      = !static_oe_req_i;
  assign serial_request_to_send_n_o    = !serial_rts_req_i;

  // internal reset, pulled by the pin and by the watchdog alike
  assign core_reset_n_o                = r_q.core_rst_n;

  // reference enable: the pll multiplies it, the mac transmit path uses it raw
  assign pll_ref_tick_o                = r_q.ref_tick;
  assign pll_mult_o                    = 8'(`CRSS_PLL_MULT);
  assign mac_tx_clk_tick_o             = r_q.ref_tick;

  // strap 1 is a factory bypass: the pll is then not the cpu clock
  assign cpu_clk_from_pll_o            = !r_q.clk_strap;

endmodule

`default_nettype wire

// file: tb_top.sv
// self-checking bench for the chip reset and strap sequencer
// assumes a 50 MHz clock and a shortened stretch of 8 ticks
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int ST = 8;
  logic clk = 1'b0, rst_n = 1'b0, wd = 1'b0, oe_r = 1'b0, rts_r = 1'b0;
  logic hold = 1'b0, pol = 1'b0, csel = 1'b0;
  logic pin_n, pol_s, clk_s, ro, ro_oe, se_n, se_oe, rt_n, rt_oe, pads, core_n, tick, fromp, mtick;
  logic [7:0] mult;
  int n_fail = 0, checks = 0, cyc = 0;
  crss_board i_crss_board (.ref_clk_i(clk), .hold_i(hold), .pol_i(pol), .csel_i(csel),
    .chip_reset_in_n_o(pin_n), .pol_strap_o(pol_s), .clk_strap_o(clk_s));
  crss_sequencer #(.STRETCH_TICKS(ST)) i_crss_sequencer (.ref_clk_i(clk), .rst_n_i(rst_n),
    .chip_reset_in_n_i(pin_n), .watchdog_expire_i(wd), .reset_out_polarity_strap_i(pol_s),
    .cpu_clock_source_strap_i(clk_s), .static_oe_req_i(oe_r), .serial_rts_req_i(rts_r),
    .system_reset_out_o(ro), .system_reset_out_oe_o(ro_oe), .static_output_enable_n_o(se_n),
    .static_output_enable_n_oe_o(se_oe), .serial_request_to_send_n_o(rt_n),
    .serial_request_to_send_n_oe_o(rt_oe), .chip_outputs_en_o(pads), .core_reset_n_o(core_n),
    .pll_ref_tick_o(tick), .pll_mult_o(mult), .cpu_clk_from_pll_o(fromp), .mac_tx_clk_tick_o(mtick));
  initial forever #10 clk = ~clk;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic wait_core(output int n);
    n = 0;
    while (core_n !== 1'b1 && n < 2000) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic t_chip(input logic p, input logic c);
    int n;
    @(posedge clk);
    hold <= 1'b1;
    pol <= p;
    csel <= c;
    repeat (300) @(posedge clk);
    #1;
    chk("pads_oe", 8'h0, {5'h0, rt_oe, se_oe, pads});
    chk("rst_out_on", {7'h0, !p}, {7'h0, ro});
    chk("rst_out_oe", 8'h1, {7'h0, ro_oe});
    @(posedge clk);
    hold <= 1'b0;
    wait_core(n);
    chk("stretch", 8'h1, {7'h0, n >= 2 * ST && n <= 2 * ST + 8});
    chk("rst_out_off", {7'h0, p}, {7'h0, ro});
    chk("cpu_clk_src", {7'h0, !c}, {7'h0, fromp});
    chk("pads_on", 8'h7, {5'h0, rt_oe, se_oe, pads});
    repeat (20) @(posedge clk);
    #1;
    chk("strap_held", {7'h0, !c}, {7'h0, fromp});
    chk("pol_held", {7'h0, p}, {7'h0, ro});
  endtask
  task automatic t_pins();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      oe_r <= i[0];
      rts_r <= i[1];
      @(posedge clk);
      #1;
      chk("pins", {6'h0, !i[1], !i[0]}, {6'h0, rt_n, se_n});
      chk("mult", 8'h05, mult);
      chk("mac_tick", {7'h0, tick}, {7'h0, mtick});
    end
  endtask
  task automatic t_wd();
    int n;
    @(posedge clk);
    wd <= 1'b1;
    @(posedge clk);
    wd <= 1'b0;
    #1;
    chk("wd_core", 8'h0, {7'h0, core_n});
    chk("wd_rst_out", {7'h0, !pol}, {7'h0, ro});
    repeat (6) @(posedge clk);
    wd <= 1'b1;
    @(posedge clk);
    wd <= 1'b0;
    wait_core(n);
    chk("wd_restart", 8'h1, {7'h0, n >= 2 * ST - 2 && n <= 2 * ST + 2});
    chk("wd_pads_on", 8'h7, {5'h0, rt_oe, se_oe, pads});
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) t_chip(i[1], i[0]);
    t_pins();
    t_wd();
    tally_and_finish();
  end
endmodule
`default_nettype wire
